// [hw/cpc_pkg.sv]
package cpc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ             = 125;      // core clock rate
    localparam int ALERT_PULSE_US      = 128;      // alert pulse length
    localparam int ALERT_PULSE_CYC     = ALERT_PULSE_US * CLK_MHZ;
    localparam int DEBOUNCE_US         = 1;        // input filter time
    localparam int DEBOUNCE_CYC        = DEBOUNCE_US * CLK_MHZ;
    localparam int WAKE_DEFAULT_MS     = 125;      // wake timer default
    localparam int WAKE_DEFAULT_CYC    = WAKE_DEFAULT_MS * CLK_MHZ * 1000;
    localparam int RESET_HOLD_MS       = 8000;     // button reset hold
    localparam int RESET_HOLD_CYC      = RESET_HOLD_MS * CLK_MHZ * 1000;

    // ------------------------------------------------------------
    // system rail setting
    // ------------------------------------------------------------
    localparam logic [2:0] RAIL_PASS_THROUGH = 3'h7;  // input pass-through code

    // ------------------------------------------------------------
    // role of the power-good pin
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PG_ROLE_POWER  = 2'h0,  // input-good indication
        PG_ROLE_BUTTON = 2'h1,  // level-shifted button
        PG_ROLE_GPO    = 2'h2   // software open drain
    } cpc_pg_role_t;

    // analog comparator results gathered together
    typedef struct packed
    {
        logic vin_present;      // input supply detected
        logic vin_above_sleep;  // input above battery plus sleep margin
        logic vin_below_ovp;    // input below overvoltage limit
    } cpc_supply_t;

    // control bits from the serial register block
    typedef struct packed
    {
        logic         alert_mask;   // suppress alert pulses
        cpc_pg_role_t pg_role;      // role of power-good pin
        logic         gpo_level;    // 1 releases the gpo pin
        logic [2:0]   rail_setting; // system rail setting
    } cpc_ctrl_t;

endpackage

// [hw/cpc_filter.sv]
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser followed by a stable-count debounce
module cpc_filter #(
    parameter int FILT_CYC = 125,
    parameter bit RST_VAL  = 1'b0
) (
    input  wire logic core_clk,
    input  wire logic rst_sync_b,
    input  wire logic pin_in,
    output logic      level_out
);
    import cpc_pkg::*;

    localparam int CW = $clog2(FILT_CYC + 1);

    initial
    begin
        if (FILT_CYC < 1)
            $error("cpc_filter: FILT_CYC must be at least 1");
    end

    logic          meta_q;      // first stage, read only by sync_q
    logic          sync_q;      // second stage
    logic          level_q;     // debounced level
    logic          level_d;
    logic [CW-1:0] cnt_q;       // cycles the new level has held
    logic [CW-1:0] cnt_d;

    // ------------------------------------------------------------
    // debounce next state
    // ------------------------------------------------------------
    always_comb
    begin
        level_d = level_q;
        cnt_d   = '0;
        if (sync_q != level_q)
        begin
            // restart on every bounce; only a steady level gets through
            if (cnt_q == CW'(FILT_CYC - 1))
                level_d = sync_q;
            else
                cnt_d = cnt_q + CW'(1);
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            meta_q  <= RST_VAL;
            sync_q  <= RST_VAL;
            level_q <= RST_VAL;
            cnt_q   <= '0;
        end
        else
        begin
            meta_q  <= pin_in;
            sync_q  <= meta_q;
            level_q <= level_d;
            cnt_q   <= cnt_d;
        end
    end

    assign level_out = level_q;

endmodule

`default_nettype wire

// [hw/cpc_top.sv]
`timescale 1ns/1ps
`default_nettype none

module cpc_top
    import cpc_pkg::*;
#(
    parameter int WAKE_HOLD_CYC  = cpc_pkg::WAKE_DEFAULT_CYC,
    parameter int RESET_HOLD_CY  = cpc_pkg::RESET_HOLD_CYC,
    parameter int PULSE_CYC      = cpc_pkg::ALERT_PULSE_CYC,
    parameter int FILTER_CYC     = cpc_pkg::DEBOUNCE_CYC
) (
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic         charge_enable_n,     // pin, low or floating enables
    input  wire logic         low_power_request_n, // pin, low asks for low power
    input  wire logic         push_button_in,      // pin, low while pressed
    input  wire cpc_supply_t  supply,              // analog comparators
    input  wire cpc_ctrl_t    ctrl,                // serial register bits
    input  wire logic         fault_event,         // one-cycle fault strobe
    input  wire logic         ship_mode,           // device is in ship mode
    output logic              charge_allow,        // charger may run
    output logic              low_power_mode,      // low power mode active
    output logic              alert_o,             // alert pin output value
    output logic              alert_oe_n,          // low while alert pin driven
    output logic              input_good_o,        // power-good output value
    output logic              input_good_oe_n,     // low while power-good driven
    output logic              rail_pass_through,   // system rail passes input
    output logic              ship_wake,           // one-cycle wake pulse
    output logic              rail_cycle           // one-cycle hardware reset pulse
);
    import cpc_pkg::*;

    localparam int PW = $clog2(PULSE_CYC + 1);
    localparam int HW = $clog2(RESET_HOLD_CY + 1);

    initial
    begin
        if (PULSE_CYC < 1 || WAKE_HOLD_CYC < 1 || RESET_HOLD_CY <= WAKE_HOLD_CYC)
            $error("cpc_top: hold and pulse counts out of range");
    end

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_q;   // first reset flop
    logic rst_sync_b;   // released reset for the block

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_b <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // pin filtering
    // ------------------------------------------------------------
    logic ce_n_f;   // filtered charge enable, floating reads low
    logic lp_n_f;   // filtered low power request
    logic btn_f;    // filtered button, idle high

    cpc_filter #(.FILT_CYC(FILTER_CYC), .RST_VAL(1'b0)) u_ce_filt
    (
        .core_clk   (core_clk),
        .rst_sync_b (rst_sync_b),
        .pin_in     (charge_enable_n),
        .level_out  (ce_n_f)
    );

    cpc_filter #(.FILT_CYC(FILTER_CYC), .RST_VAL(1'b0)) u_lp_filt
    (
        .core_clk   (core_clk),
        .rst_sync_b (rst_sync_b),
        .pin_in     (low_power_request_n),
        .level_out  (lp_n_f)
    );

    cpc_filter #(.FILT_CYC(FILTER_CYC), .RST_VAL(1'b1)) u_btn_filt
    (
        .core_clk   (core_clk),
        .rst_sync_b (rst_sync_b),
        .pin_in     (push_button_in),
        .level_out  (btn_f)
    );

    // ------------------------------------------------------------
    // supply and mode decode
    // ------------------------------------------------------------
    logic charge_d;     // next charge permission
    logic lowp_d;       // next low power state
    logic pass_d;       // next pass-through select
    logic vin_window;   // input inside power-good window

    // comparator inputs are treated as same-domain analog flags
    always_comb
    begin
        vin_window = supply.vin_above_sleep & supply.vin_below_ovp;
        charge_d   = supply.vin_present & ~ce_n_f;
        // host keeps request high for bus access, nothing to enforce here
        lowp_d     = ~supply.vin_present & ~lp_n_f;
        pass_d     = (ctrl.rail_setting == RAIL_PASS_THROUGH);
    end

    // ------------------------------------------------------------
    // alert pulse
    // ------------------------------------------------------------
    logic [PW-1:0] pulse_cnt_q;    // remaining pulse cycles
    logic [PW-1:0] pulse_cnt_d;
    logic          alert_drv_d;    // alert pulled low next cycle

    always_comb
    begin
        pulse_cnt_d = pulse_cnt_q;
        if (fault_event && !ctrl.alert_mask && pulse_cnt_q == '0)
            pulse_cnt_d = PW'(PULSE_CYC);
        else if (pulse_cnt_q != '0)
            pulse_cnt_d = pulse_cnt_q - PW'(1);
        alert_drv_d = (pulse_cnt_d != '0);
    end

    // ------------------------------------------------------------
    // push button hold timing
    // ------------------------------------------------------------
    logic [HW-1:0] hold_cnt_q;     // cycles the button has been low
    logic [HW-1:0] hold_cnt_d;
    logic          wake_d;
    logic          cycle_d;

    always_comb
    begin
        wake_d  = 1'b0;
        cycle_d = 1'b0;
        if (btn_f)
            hold_cnt_d = '0;
        else if (hold_cnt_q != HW'(RESET_HOLD_CY))
            hold_cnt_d = hold_cnt_q + HW'(1);
        else
            hold_cnt_d = hold_cnt_q;   // saturate: each of wake and reset fires at most once per press
        if (ship_mode && hold_cnt_d == HW'(WAKE_HOLD_CYC) && hold_cnt_q != hold_cnt_d)
            wake_d = 1'b1;
        if (hold_cnt_d == HW'(RESET_HOLD_CY) && hold_cnt_q != hold_cnt_d)
            cycle_d = 1'b1;
    end

    // ------------------------------------------------------------
    // power-good pin role
    // ------------------------------------------------------------
    logic pg_oe_n_d;   // low drives the pin low

    always_comb
    begin
        case (ctrl.pg_role)
            PG_ROLE_POWER:  pg_oe_n_d = ~vin_window;
            PG_ROLE_BUTTON: pg_oe_n_d = btn_f;
            PG_ROLE_GPO:    pg_oe_n_d = ctrl.gpo_level;
            default:        pg_oe_n_d = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            pulse_cnt_q       <= '0;
            hold_cnt_q        <= '0;
            charge_allow      <= 1'b0;
            low_power_mode    <= 1'b0;
            rail_pass_through <= 1'b0;
            alert_oe_n        <= 1'b1;
            input_good_oe_n   <= 1'b1;
            ship_wake         <= 1'b0;
            rail_cycle        <= 1'b0;
        end
        else
        begin
            pulse_cnt_q       <= pulse_cnt_d;
            hold_cnt_q        <= hold_cnt_d;
            charge_allow      <= charge_d;
            low_power_mode    <= lowp_d;
            rail_pass_through <= pass_d;
            alert_oe_n        <= ~alert_drv_d;
            input_good_oe_n   <= pg_oe_n_d;
            ship_wake         <= wake_d;
            rail_cycle        <= cycle_d;
        end
    end

    // open-drain pins only ever drive low
    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            alert_o      <= 1'b0;
            input_good_o <= 1'b0;
        end
        else
        begin
            alert_o      <= 1'b0;
            input_good_o <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// [verification/cpc_top_properties.sv]
`timescale 1ns/1ps
`default_nettype none

// ------
// pin control checks
// ------
module cpc_top_properties #(
    parameter int WAKE_HOLD_CYC = 20,
    parameter int RESET_HOLD_CY = 40,
    parameter int PULSE_CYC     = 8
) (
    input wire logic                 core_clk,
    input wire logic                 rst_b,
    input wire logic                 push_button_in,
    input wire cpc_pkg::cpc_supply_t supply,
    input wire cpc_pkg::cpc_ctrl_t   ctrl,
    input wire logic                 fault_event,
    input wire logic                 ship_mode,
    input wire logic                 charge_allow,
    input wire logic                 low_power_mode,
    input wire logic                 alert_o,
    input wire logic                 alert_oe_n,
    input wire logic                 input_good_o,
    input wire logic                 input_good_oe_n,
    input wire logic                 rail_pass_through,
    input wire logic                 ship_wake,
    input wire logic                 rail_cycle
);
    import cpc_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic [2:0] up_q;   // edges since release
    logic [2:0] up_d;
    int         lo_q;   // alert low run
    int         lo_d;
    int         btn_q;  // raw button low run
    int         btn_d;
    logic       rdy;    // reset synchroniser has let go
    // next values; raw button run is a ceiling for the filtered one
    always_comb
    begin
        up_d  = {up_q[1:0], 1'h1};
        lo_d  = alert_oe_n ? 0 : lo_q + 1;
        btn_d = push_button_in ? 0 : btn_q + 1;
    end
    // registers, cleared by the raw reset
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            up_q  <= 3'h0;
            lo_q  <= 0;
            btn_q <= 0;
        end
        else
        begin
            up_q  <= up_d;
            lo_q  <= lo_d;
            btn_q <= btn_d;
        end
    end
    assign rdy = &up_q;
    a_alert_start: assert property (
        rdy && fault_event && !ctrl.alert_mask && alert_oe_n |=> !alert_oe_n)
        else $error("alert pulse did not start");
    a_alert_width: assert property ($rose(alert_oe_n) |-> lo_q == PULSE_CYC)
        else $error("alert pulse width wrong");
    a_alert_long: assert property (!alert_oe_n |-> lo_q < PULSE_CYC)
        else $error("alert pulse too long");
    a_alert_masked: assert property (rdy && ctrl.alert_mask && alert_oe_n |=> alert_oe_n)
        else $error("masked alert pulsed");
    a_pins_low: assert property (alert_o == 1'h0 && input_good_o == 1'h0)
        else $error("open drain value not low");
    a_charge_off: assert property (rdy && !supply.vin_present |=> !charge_allow)
        else $error("charge without supply");
    a_lp_ignored: assert property (rdy && supply.vin_present |=> !low_power_mode)
        else $error("low power with supply");
    a_rail_code: assert property (
        rdy |=> rail_pass_through == ($past(ctrl.rail_setting) == RAIL_PASS_THROUGH))
        else $error("pass-through wrong");
    a_pg_window: assert property (rdy && ctrl.pg_role == PG_ROLE_POWER |=>
        input_good_oe_n == !($past(supply.vin_above_sleep) && $past(supply.vin_below_ovp)))
        else $error("power good wrong");
    a_pg_gpo: assert property (
        rdy && ctrl.pg_role == PG_ROLE_GPO |=> input_good_oe_n == $past(ctrl.gpo_level))
        else $error("gpo pin wrong");
    a_wake_cause: assert property (
        ship_wake |-> $past(ship_mode) && btn_q >= WAKE_HOLD_CYC ##1 !ship_wake)
        else $error("wake pulse wrong");
    a_reset_hold: assert property (rail_cycle |-> btn_q >= RESET_HOLD_CY ##1 !rail_cycle)
        else $error("rail cycle pulse wrong");
    c_alert: cover property (!alert_oe_n);
    c_wake: cover property (ship_wake);
    c_rail: cover property (rail_cycle);
endmodule

`default_nettype wire

// [verification/cpc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// host side: pull-ups on both open-drain pins, request pin driver
module cpc_host_model (
    input  wire logic alert_oe_n,
    input  wire logic input_good_oe_n,
    input  wire logic want_low_power,
    output logic      alert_wire,
    output logic      input_good_wire,
    output logic      low_power_request_n,
    output var int    alert_seen
);
    // released pins read high through the pull-ups
    assign alert_wire      = alert_oe_n ? 1'h1 : 1'h0;
    assign input_good_wire = input_good_oe_n ? 1'h1 : 1'h0;
    // request driven low only while want_low_power is set
    // pin idles high so bus access on battery stays possible
    assign low_power_request_n = !want_low_power;
    // host counts pulses
    // each falling edge is one interrupt seen by the host
    initial alert_seen = 0;
    always @(negedge alert_wire)
        alert_seen++;
endmodule

`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
    import cpc_pkg::*;
    localparam int WAKE   = 20;
    localparam int HOLD   = 40;
    localparam int PULSE  = 8;
    localparam int FILT   = 2;
    localparam int SETTLE = FILT + 6;  // pin to output, with margin
    logic        core_clk        = 1'h0;
    logic        rst_b           = 1'h0;
    logic        charge_enable_n = 1'h0;
    logic        push_button_in  = 1'h1;
    cpc_supply_t supply          = '0;
    cpc_ctrl_t   ctrl            = '0;
    logic        fault_event     = 1'h0;
    logic        ship_mode       = 1'h0;
    logic        want_low_power  = 1'h0;
    wire logic   low_power_request_n;
    wire logic   alert_wire;
    wire logic   input_good_wire;
    logic        charge_allow;
    logic        low_power_mode;
    logic        alert_o;
    logic        alert_oe_n;
    logic        input_good_o;
    logic        input_good_oe_n;
    logic        rail_pass_through;
    logic        ship_wake;
    logic        rail_cycle;
    int          alert_seen;
    int          fails           = 0;
    int          checked         = 0;
    int          wakes           = 0;
    int          resets          = 0;
    int          n;

    always #4 core_clk = ~core_clk;

    cpc_top #(.WAKE_HOLD_CYC(WAKE), .RESET_HOLD_CY(HOLD), .PULSE_CYC(PULSE),
        .FILTER_CYC(FILT)) dut_u (.*);
    cpc_host_model host_u (.*);

    // count one-cycle pulses of the button logic
    always @(posedge core_clk)
    begin
        if (ship_wake === 1'h1)
            wakes++;
        if (rail_cycle === 1'h1)
            resets++;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(negedge core_clk);
    endtask

    // fault now, a second one gap + 1 cycles later; counts low cycles
    task automatic burst(input int gap, input logic mask, output int low);
        low = 0;
        ctrl.alert_mask = mask;
        fault_event = 1'h1;
        for (int i = 0; i < 30; i++)
        begin
            tick(1);
            fault_event = (i == gap);
            if (!alert_wire)
                low++;
        end
    endtask

    task automatic press(input int c);
        push_button_in = 1'h0;
        tick(c);
        push_button_in = 1'h1;
        tick(SETTLE);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        tick(10);
        rst_b = 1'h1;
        tick(5);
        supply = 3'h7;
        tick(SETTLE);
        chk("charge on", 1'h1, charge_allow);
        charge_enable_n = 1'h1;
        tick(1);
        charge_enable_n = 1'h0;
        tick(SETTLE);
        chk("charge glitch", 1'h1, charge_allow);
        charge_enable_n = 1'h1;
        want_low_power = 1'h1;
        tick(SETTLE);
        chk("charge off", 1'h0, charge_allow);
        chk("lp with supply", 1'h0, low_power_mode);
        supply = 3'h0;
        charge_enable_n = 1'h0;
        tick(SETTLE);
        chk("charge no supply", 1'h0, charge_allow);
        chk("lp on battery", 1'h1, low_power_mode);
        want_low_power = 1'h0;
        tick(SETTLE);
        chk("lp released", 1'h0, low_power_mode);
        burst(3, 1'h0, n);
        chk("alert width", PULSE, n);
        burst(10, 1'h0, n);
        chk("alert pair", 2 * PULSE, n);
        burst(3, 1'h1, n);
        chk("alert masked", 0, n);
        chk("alerts seen", 3, alert_seen);
        // input window: above sleep margin and below overvoltage
        for (int k = 0; k < 8; k++)
        begin
            supply = k[2:0];
            tick(2);
            chk("pg window", k[1:0] != 2'h3, input_good_wire);
        end
        ctrl.pg_role = PG_ROLE_BUTTON;
        push_button_in = 1'h0;
        tick(SETTLE);
        chk("pg button low", 1'h0, input_good_wire);
        push_button_in = 1'h1;
        tick(SETTLE);
        chk("pg button high", 1'h1, input_good_wire);
        ctrl.pg_role = PG_ROLE_GPO;
        for (int k = 0; k < 3; k++)
        begin
            ctrl.gpo_level = k[0];
            ctrl.pg_role = (k == 2) ? cpc_pg_role_t'(2'h3) : PG_ROLE_GPO;
            tick(2);
            chk("pg gpo", k[0] || k == 2, input_good_wire);
        end
        for (int k = 0; k < 8; k++)
        begin
            ctrl.rail_setting = k[2:0];
            tick(2);
            chk("rail mode", k[2:0] == 3'h7, rail_pass_through);
        end
        // 0.125 s of 8 ns cycles
        chk("wake default", 32'hEE6B28, WAKE_DEFAULT_CYC);
        ship_mode = 1'h1;
        press(WAKE - 3);
        chk("wake too short", 0, wakes);
        press(WAKE + SETTLE);
        chk("wake", 1, wakes);
        chk("no reset", 0, resets);
        press(HOLD + SETTLE);
        chk("wake long", 2, wakes);
        chk("reset long", 1, resets);
        ship_mode = 1'h0;
        press(HOLD + SETTLE);
        chk("wake awake", 2, wakes);
        chk("reset awake", 2, resets);
        results();
    end
endmodule

bind cpc_top cpc_top_properties #(.WAKE_HOLD_CYC(WAKE_HOLD_CYC),
    .RESET_HOLD_CY(RESET_HOLD_CY), .PULSE_CYC(PULSE_CYC)) chk_u (.*);

`default_nettype wire
